//--- hdl/ipsr_src.sv
// Purpose: sticky pending flag of one interrupt source
// Assumes: event and clear are synchronous one-cycle pulses or levels
// Notes:   an event in the clearing cycle keeps the flag set
`default_nettype none

module ipsr_src
  import ipsr_pkg::*;
#(
  parameter logic RST_PEND = 1'b0
)
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic event_in,
  input  wire logic clear_in,
  output logic      pending
);

  ipsr_src_st_t s_q;
  ipsr_src_st_t s_d;

  // set wins over clear
  always_comb
  begin
    s_d = s_q;
    if (event_in)
    begin
      s_d.pend = 1'b1;
    end
    else if (clear_in)
    begin
      s_d.pend = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{pend: RST_PEND};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pending = s_q.pend;

  // an event is never lost to a clear
  set_wins_a: assert property (@(posedge core_clk) disable iff (rst)
    event_in |=> pending)
    else $error("source event lost");

endmodule

`default_nettype wire

//--- hdl/ipsr_top.sv
// Purpose: priority registers, control/status register and request logic
// Assumes: classic wishbone master, core acknowledges with a pulse
// Notes:   two sources; ties between equal priorities go to low voltage
`default_nettype none
`include "ipsr_params.svh"

// Contract
// - A 3-bit priority is a binary level, seven highest, one lowest.
// - A source whose priority is zero never raises a request.
// - The low voltage priority sits in bits 2..0 and is read/write.
// - Unused priority register bits read zero and ignore writes.
// - Status word: pending bit 15, capture bit 13, level 11..8, vector 6..0.
// - With capture set the vector field shows the best pending source.
// - With capture clear the vector field shows the last acknowledged one.
// - The pending bit is one from request raised until core acknowledge.
module ipsr_top
  import ipsr_pkg::*;
#(
  parameter logic [6:0] LVD_VEC = 7'h48, // arbitrary vector number
  parameter logic [6:0] CTM_VEC = 7'h58  // arbitrary vector number
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        lvd_event,
  input  wire logic        ctm_event,
  input  wire logic [3:0]  cpu_level,
  input  wire logic        cpu_irq_ack,
  output logic             cpu_irq_req,
  output logic [3:0]       cpu_irq_level,
  output logic [6:0]       cpu_irq_vector
);

  ipsr_state_t s_q;
  ipsr_state_t s_d;

  logic        lvd_pend;
  logic        ctm_pend;
  logic        lvd_clr;
  logic        ctm_clr;
  logic        lvd_on;
  logic        ctm_on;
  logic        pick_lvd;
  logic        best_valid;
  logic [2:0]  best_prio;
  logic [6:0]  best_vec;
  logic        raise;
  logic        take_ack;
  logic        bus_req;
  logic        wr_go;
  logic [6:0]  vec_field;
  logic [31:0] ics_word;

  // per-source sticky pending flags
  ipsr_src #(
    .RST_PEND (1'b0)
  ) u_lvd (
    .core_clk (core_clk),
    .rst      (rst),
    .event_in (lvd_event),
    .clear_in (lvd_clr),
    .pending  (lvd_pend)
  );

  ipsr_src #(
    .RST_PEND (1'b0)
  ) u_ctm (
    .core_clk (core_clk),
    .rst      (rst),
    .event_in (ctm_event),
    .clear_in (ctm_clr),
    .pending  (ctm_pend)
  );

  // arbitration between the two sources
  assign lvd_on     = lvd_pend && (s_q.lvd_prio != `IPSR_OFF_PRIO);
  assign ctm_on     = ctm_pend && (s_q.ctm_prio != `IPSR_OFF_PRIO);
  assign pick_lvd   = lvd_on && (!ctm_on || s_q.lvd_prio >= s_q.ctm_prio);
  assign best_valid = lvd_on || ctm_on;
  assign best_prio  = pick_lvd ? s_q.lvd_prio : s_q.ctm_prio;
  assign best_vec   = pick_lvd ? LVD_VEC : CTM_VEC;
  assign raise      = (s_q.st == IPSR_IDLE) && best_valid
                      && ({1'b0, best_prio} > cpu_level);

  // acknowledge from the core clears the served source
  assign take_ack = (s_q.st == IPSR_REQ) && cpu_irq_ack;
  assign lvd_clr  = take_ack && s_q.req_lvd;
  assign ctm_clr  = take_ack && !s_q.req_lvd;

  // vector field source selected by capture mode
  assign vec_field = s_q.cap ? best_vec : s_q.ack_vec;

  // bus strobes
  assign bus_req = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
  assign wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && s_q.wb_ack;

  // status word image
  always_comb
  begin
    ics_word = 32'h0000_0000;
    ics_word[`IPSR_PEND_BIT] = (s_q.st == IPSR_REQ);
    ics_word[`IPSR_CAP_BIT] = s_q.cap;
    ics_word[`IPSR_LVL_LSB +: 4] = s_q.req_lvl;
    ics_word[`IPSR_VEC_LSB +: 7] = vec_field;
  end

  // next state: bus, registers and request handshake
  always_comb
  begin
    s_d = s_q;
    s_d.wb_ack = bus_req;
    // read data captured as ack rises
    if (bus_req)
    begin
      s_d.rdata = 32'h0000_0000;
      if (wb_adr_i == `IPSR_ADR_LVD)
      begin
        s_d.rdata[`IPSR_LVD_LSB +: 3] = s_q.lvd_prio;
      end
      else if (wb_adr_i == `IPSR_ADR_CTM)
      begin
        s_d.rdata[`IPSR_CTM_LSB +: 3] = s_q.ctm_prio;
      end
      else if (wb_adr_i == `IPSR_ADR_ICS)
      begin
        s_d.rdata = ics_word;
      end
    end
    // writes land on the edge that sees ack; priority fields sit in the low byte, capture in byte 1
    if (wr_go && wb_sel_i[0])
    begin
      if (wb_adr_i == `IPSR_ADR_LVD)
      begin
        s_d.lvd_prio = wb_dat_i[`IPSR_LVD_LSB +: 3];
      end
      else if (wb_adr_i == `IPSR_ADR_CTM)
      begin
        s_d.ctm_prio = wb_dat_i[`IPSR_CTM_LSB +: 3];
      end
    end
    if (wr_go && wb_sel_i[1] && wb_adr_i == `IPSR_ADR_ICS)
    begin
      s_d.cap = wb_dat_i[`IPSR_CAP_BIT];
    end
    // request handshake
    case (s_q.st)
      IPSR_IDLE:
      begin
        if (raise)
        begin
          s_d.st      = IPSR_REQ;
          s_d.req_lvl = {1'b0, best_prio};
          s_d.req_vec = best_vec;
          s_d.req_lvd = pick_lvd;
        end
      end
      IPSR_REQ:
      begin
        if (cpu_irq_ack)
        begin
          s_d.st      = IPSR_IDLE;
          s_d.ack_vec = s_q.req_vec;
        end
      end
      default:
      begin
        s_d.st = IPSR_IDLE;
      end
    endcase
  end

  // state register, priorities load level four
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{st:       IPSR_IDLE,
               lvd_prio: `IPSR_PRIO_RST,
               ctm_prio: `IPSR_PRIO_RST,
               cap:      1'b0,
               req_lvl:  4'h0,
               req_vec:  7'h00,
               req_lvd:  1'b0,
               ack_vec:  7'h00,
               wb_ack:   1'b0,
               rdata:    32'h0000_0000};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign wb_ack_o       = s_q.wb_ack;
  assign wb_dat_o       = s_q.rdata;
  assign cpu_irq_req    = (s_q.st == IPSR_REQ);
  assign cpu_irq_level  = s_q.req_lvl;
  assign cpu_irq_vector = s_q.req_vec;

  // higher priority wins the request
  pick_high_a: assert property (@(posedge core_clk) disable iff (rst)
    (s_q.st == IPSR_IDLE) && lvd_on && ctm_on
    && (s_q.ctm_prio > s_q.lvd_prio) && ({1'b0, s_q.ctm_prio} > cpu_level)
    |=> cpu_irq_req && (cpu_irq_vector == CTM_VEC))
    else $error("lower priority source won");

  // disabled sources never request
  disabled_src_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cpu_irq_req) |-> (cpu_irq_level != 4'h0))
    else $error("request with priority zero");

  // low voltage field readback
  lvd_read_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_req && !wb_we_i && (wb_adr_i == `IPSR_ADR_LVD)
    |=> wb_ack_o && (wb_dat_o == {29'h0000_0000, $past(s_q.lvd_prio)}))
    else $error("low voltage priority readback wrong");

  // unused bits of the charge register stay zero
  ctm_unused_a: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o && !wb_we_i && (wb_adr_i == `IPSR_ADR_CTM)
    |-> (wb_dat_o[31:7] == 25'h000_0000) && (wb_dat_o[3:0] == 4'h0))
    else $error("unused priority bits not zero");

  // status word layout
  ics_layout_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_req && !wb_we_i && (wb_adr_i == `IPSR_ADR_ICS)
    |=> (wb_dat_o[15] == $past(cpu_irq_req))
        && (wb_dat_o[11:8] == $past(cpu_irq_level))
        && (wb_dat_o[14] == 1'b0) && (wb_dat_o[7] == 1'b0))
    else $error("status word layout wrong");

  // reset level of both priority fields
  prio_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> (s_q.lvd_prio == 3'h4) && (s_q.ctm_prio == 3'h4))
    else $error("priority reset level wrong");

  // charge priority write lands in bits 6..4
  ctm_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_go && wb_sel_i[0] && (wb_adr_i == `IPSR_ADR_CTM)
    |=> s_q.ctm_prio == $past(wb_dat_i[6:4]))
    else $error("charge priority write lost");

  // capture mode shows the live winner
  vec_live_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.cap && lvd_on && !ctm_on |-> vec_field == LVD_VEC)
    else $error("live vector not shown");

  // hold mode keeps the vector until an acknowledge
  vec_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !s_q.cap && !take_ack ##1 !s_q.cap |-> vec_field == $past(vec_field))
    else $error("held vector changed");

  // pending flag held until acknowledged, then dropped
  pend_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    cpu_irq_req && !cpu_irq_ack |=> cpu_irq_req)
    else $error("request dropped without acknowledge");

  pend_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    cpu_irq_req && cpu_irq_ack
    |=> !cpu_irq_req && (s_q.ack_vec == $past(cpu_irq_vector)))
    else $error("acknowledge not taken");

  // bus ack is a single cycle
  ack_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // main scenarios
  raise_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(cpu_irq_req));
  ack_c: cover property (@(posedge core_clk) disable iff (rst)
    cpu_irq_req && cpu_irq_ack);
  live_c: cover property (@(posedge core_clk) disable iff (rst)
    s_q.cap && best_valid && wb_ack_o && (wb_adr_i == `IPSR_ADR_ICS));
  write_c: cover property (@(posedge core_clk) disable iff (rst)
    wr_go && (wb_adr_i == `IPSR_ADR_LVD));

endmodule

`default_nettype wire

//--- shared/ipsr_params.svh
// Purpose: offsets, field positions and reset values of the priority slice
// Assumes: included by its bare name from design files
// Notes:   byte offsets on a 32-bit classic wishbone bus
`ifndef IPSR_PARAMS_SVH
`define IPSR_PARAMS_SVH

// register byte offsets
`define IPSR_ADR_LVD   8'h00
`define IPSR_ADR_CTM   8'h04
`define IPSR_ADR_ICS   8'h08

// field positions
`define IPSR_LVD_LSB   0
`define IPSR_CTM_LSB   4
`define IPSR_VEC_LSB   0
`define IPSR_LVL_LSB   8
`define IPSR_CAP_BIT   13
`define IPSR_PEND_BIT  15

// priority reset value and disabled priority
`define IPSR_PRIO_RST  3'h4
`define IPSR_OFF_PRIO  3'h0

`endif

//--- shared/ipsr_pkg.sv
// Purpose: types shared by the priority slice modules
// Assumes: nothing beyond a SystemVerilog compiler
// Notes:   all module state is carried as one packed struct
`default_nettype none

package ipsr_pkg;

  // request handshake toward the core
  typedef enum logic [0:0] {
    IPSR_IDLE = 1'b0,
    IPSR_REQ  = 1'b1
  } ipsr_req_st_t;

  // state of one source pending flag
  typedef struct packed {
    logic pend;
  } ipsr_src_st_t;

  // state of the top module
  typedef struct packed {
    ipsr_req_st_t st;
    logic [2:0]   lvd_prio;
    logic [2:0]   ctm_prio;
    logic         cap;
    logic [3:0]   req_lvl;
    logic [6:0]   req_vec;
    logic         req_lvd;
    logic [6:0]   ack_vec;
    logic         wb_ack;
    logic [31:0]  rdata;
  } ipsr_state_t;

endpackage

`default_nettype wire

//--- test/interrupt_priority_status_regs_bench.sv
// Purpose: self-checking bench for the interrupt priority slice
// Assumes: default vector parameters 7'h48 and 7'h58
// Notes:   the core model acknowledges only while ack_en is high
`default_nettype none

module interrupt_priority_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'h0;
  logic        rst      = 1'h1;
  logic        cyc      = 1'h0;
  logic        stb      = 1'h0;
  logic        we       = 1'h0;
  logic [7:0]  adr      = 8'h00;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        lvd      = 1'h0;
  logic        ctm      = 1'h0;
  logic [3:0]  lvl      = 4'h0;
  logic        ack_en   = 1'h0;
  logic        req;
  logic        irq_ack;
  logic [3:0]  irq_lvl;
  logic [6:0]  irq_vec;
  logic [31:0] q;
  int          miscompares = 0;
  int          checked     = 0;

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  ipsr_top dut
  (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .lvd_event(lvd), .ctm_event(ctm),
    .cpu_level(lvl), .cpu_irq_ack(irq_ack), .cpu_irq_req(req),
    .cpu_irq_level(irq_lvl), .cpu_irq_vector(irq_vec)
  );

  ipsr_core_model core
  (
    .core_clk(core_clk), .rst(rst), .ack_en(ack_en),
    .cpu_irq_req(req), .cpu_irq_ack(irq_ack)
  );

  task automatic test_done;
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1)
    begin
      miscompares++;
      $display("mismatch wb ack expected 1 seen %b", ack);
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000, 4'hf);
    chk($sformatf("reg %h", a), q, e);
  endtask

  // wait at falling edges for the request line to reach v
  task automatic wreq(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (req !== v && n < 10);
    chk("req", {31'h0, req}, {31'h0, v});
  endtask

  task automatic pulse(input logic l, input logic c);
    @(posedge core_clk);
    lvd <= l;
    ctm <= c;
    @(posedge core_clk);
    lvd <= 1'h0;
    ctm <= 1'h0;
  endtask

  // let the core model take exactly one request
  task automatic serve;
    int n;
    n = 0;
    @(posedge core_clk);
    ack_en <= 1'h1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (irq_ack !== 1'h1 && n < 10);
    chk("core ack", {31'h0, irq_ack}, 32'h0000_0001);
    ack_en <= 1'h0;
  endtask

  task automatic idle_chk;
    repeat (6) @(negedge core_clk);
    chk("idle req", {31'h0, req}, 32'h0000_0000);
  endtask

  task automatic t_reset;
    rd(8'h00, 32'h0000_0004);
    rd(8'h04, 32'h0000_0040);
    rd(8'h08, 32'h0000_0000);
  endtask

  task automatic t_regs;
    wb(1'h1, 8'h00, 32'hffff_ffff, 4'hf);
    rd(8'h00, 32'h0000_0007);
    wb(1'h1, 8'h00, 32'h0000_0000, 4'he);
    rd(8'h00, 32'h0000_0007);
    wb(1'h1, 8'h04, 32'hffff_ffff, 4'hf);
    rd(8'h04, 32'h0000_0070);
    wb(1'h1, 8'h08, 32'hffff_ffff, 4'hf);
    rd(8'h08, 32'h0000_2058);
    wb(1'h1, 8'h08, 32'h0000_0000, 4'hf);
    rd(8'h08, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
  endtask

  task automatic t_order;
    wb(1'h1, 8'h00, 32'h0000_0002, 4'hf);
    wb(1'h1, 8'h04, 32'h0000_0050, 4'hf);
    pulse(1'h1, 1'h1);
    wreq(1'h1);
    chk("level", {28'h0, irq_lvl}, 32'h0000_0005);
    chk("vector", {25'h0, irq_vec}, 32'h0000_0058);
    rd(8'h08, 32'h0000_8500);
    wb(1'h1, 8'h08, 32'h0000_2000, 4'hf);
    rd(8'h08, 32'h0000_a558);
    serve;
    wreq(1'h1);
    chk("level", {28'h0, irq_lvl}, 32'h0000_0002);
    chk("vector", {25'h0, irq_vec}, 32'h0000_0048);
    rd(8'h08, 32'h0000_a248);
    wb(1'h1, 8'h08, 32'h0000_0000, 4'hf);
    rd(8'h08, 32'h0000_8258);
    serve;
    rd(8'h08, 32'h0000_0248);
  endtask

  task automatic t_mask;
    lvl <= 4'h5;
    wb(1'h1, 8'h00, 32'h0000_0005, 4'hf);
    pulse(1'h1, 1'h0);
    idle_chk;
    wb(1'h1, 8'h00, 32'h0000_0006, 4'hf);
    wreq(1'h1);
    chk("level", {28'h0, irq_lvl}, 32'h0000_0006);
    serve;
    lvl <= 4'h0;
  endtask

  task automatic t_off;
    wb(1'h1, 8'h00, 32'h0000_0000, 4'hf);
    wb(1'h1, 8'h04, 32'h0000_0000, 4'hf);
    pulse(1'h1, 1'h1);
    idle_chk;
    rd(8'h08, 32'h0000_0648);
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    t_reset;
    t_regs;
    t_order;
    t_mask;
    t_off;
    test_done;
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    test_done;
  end
endmodule

`default_nettype wire

//--- test/ipsr_core_model.sv
// Purpose: core model that acknowledges vectored requests
// Assumes: ack_en is driven off the rising clock edge
// Notes:   acks one cycle after a request, only while enabled
`default_nettype none

module ipsr_core_model
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ack_en,
  input  wire logic cpu_irq_req,
  output logic      cpu_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle ack pulse, never while the request line is low
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cpu_irq_ack <= 1'h0;
    else
      cpu_irq_ack <= ack_en & cpu_irq_req & ~cpu_irq_ack;
endmodule

`default_nettype wire
